// ==== ffr_pkg.sv ====
/*
  Constants, register map and types for the fault flag response block.
  Assumes a 40 MHz system clock and a byte-wide register port at the printed addresses.
*/
package ffr_pkg;

  localparam int unsigned CLK_MHZ = 40;

  // Register addresses
  localparam logic [15:0] ADDR_CFG_FIRST = 16'hFE00;
  localparam logic [15:0] ADDR_GLOBAL = 16'hFE06;
  localparam int unsigned NUM_CFG_REGS = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] GLOBAL_RESET = 8'h00;

  // Global register fields
  localparam int unsigned GLB_DELAY_LSB = 6;
  localparam int unsigned GLB_OV_IGNORE_BIT = 5;
  localparam int unsigned GLB_OV_DEB_BIT = 4;

  // Nibble layout within a flag configuration register
  localparam int unsigned NIB_HIGH_LSB = 4;
  localparam int unsigned NIB_LOW_LSB = 0;
  localparam int unsigned NIB_ACT_LSB = 2;
  localparam int unsigned NIB_REC_LSB = 0;

  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_CHAN_A = 2'h1;
  localparam logic [1:0] ACT_CHAN_B = 2'h2;
  localparam logic [1:0] ACT_ALL = 2'h3;
  localparam logic [1:0] REC_SOFT = 2'h0;
  localparam logic [1:0] REC_NOW = 2'h1;

  // Flag indices
  localparam int unsigned NUM_FLAGS = 13;
  localparam int unsigned FLAG_EXT = 12;

  // Timing
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam logic [10:0] DELAY_MS_0 = 11'h0FA;
  localparam logic [10:0] DELAY_MS_1 = 11'h1F4;
  localparam logic [10:0] DELAY_MS_2 = 11'h3E8;
  localparam logic [10:0] DELAY_MS_3 = 11'h7D0;
  localparam int unsigned DEB_LONG_US = 500;
  localparam int unsigned DEB_SHORT_US = 2;
  localparam int unsigned DEB_LONG_CYCLES = DEB_LONG_US * CLK_MHZ;
  localparam int unsigned DEB_SHORT_CYCLES = DEB_SHORT_US * CLK_MHZ;

  typedef enum logic [1:0] {
    FFR_IDLE = 2'h0,
    FFR_HELD = 2'h1,
    FFR_DELAY = 2'h3,
    FFR_LATCH = 2'h2
  } ffr_state_t;

endpackage : ffr_pkg

// ==== ffr_flag_if.sv ====
/*
  Carrier between the top block and one per-flag handler.
  Assumes the top drives config, flag level, tick and delay every cycle.
*/
`timescale 1ns/1ps
interface ffr_flag_if;
  logic flag;
  logic [3:0] cfg;
  logic tick;
  logic [10:0] delay_ms;
  logic power_on_request;
  logic [2:0] disable_abc;
  logic [2:0] soft_start_abc;

  modport handler (
    input flag,
    input cfg,
    input tick,
    input delay_ms,
    input power_on_request,
    output disable_abc,
    output soft_start_abc
  );

  modport owner (
    output flag,
    output cfg,
    output tick,
    output delay_ms,
    output power_on_request,
    input disable_abc,
    input soft_start_abc
  );
endinterface : ffr_flag_if

// ==== ffr_flag_handler.sv ====
/*
  Response state machine for one fault flag.
  Assumes the flag input is already detected and synchronous to clk_sys.
*/
`timescale 1ns/1ps
module ffr_flag_handler (
  input wire logic clk_sys,
  input wire logic reset,
  ffr_flag_if.handler fi
);

  ffr_pkg::ffr_state_t state_reg, state_next;
  logic [1:0] act_reg, act_next;
  logic [10:0] ms_reg, ms_next;
  logic ss_reg, ss_next;
  logic [2:0] act_mask;

  always_comb
  begin
    state_next = state_reg;
    act_next = act_reg;
    ms_next = ms_reg;
    ss_next = 1'b0;
    case (state_reg)
      ffr_pkg::FFR_IDLE:
      begin
        if (fi.flag)
        begin
          // Action sampled at the moment the flag sets
          act_next = fi.cfg[ffr_pkg::NIB_ACT_LSB +: 2];
          state_next = ffr_pkg::FFR_HELD;
        end
      end
      ffr_pkg::FFR_HELD:
      begin
        ms_next = 11'h000;
        if (!fi.flag)
        begin
          if (fi.cfg[ffr_pkg::NIB_REC_LSB + 1])
            state_next = ffr_pkg::FFR_LATCH;
          else if (fi.cfg[ffr_pkg::NIB_REC_LSB +: 2] == ffr_pkg::REC_NOW)
            state_next = ffr_pkg::FFR_IDLE;
          else
            state_next = ffr_pkg::FFR_DELAY;
        end
      end
      ffr_pkg::FFR_DELAY:
      begin
        if (fi.flag)
          state_next = ffr_pkg::FFR_HELD;
        else if (fi.tick)
        begin
          if (ms_reg + 11'h001 >= fi.delay_ms)
          begin
            ss_next = 1'b1;
            state_next = ffr_pkg::FFR_IDLE;
          end
          else
            ms_next = ms_reg + 11'h001;
        end
      end
      ffr_pkg::FFR_LATCH:
      begin
        if (fi.flag)
          state_next = ffr_pkg::FFR_HELD;
        else if (fi.power_on_request)
          state_next = ffr_pkg::FFR_IDLE;
      end
      default:
        state_next = ffr_pkg::FFR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg <= ffr_pkg::FFR_IDLE;
      act_reg <= ffr_pkg::ACT_NONE;
      ms_reg <= 11'h000;
      ss_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      act_reg <= act_next;
      ms_reg <= ms_next;
      ss_reg <= ss_next;
    end
  end

  // Bit 0 chan A, bit 1 chan B, bit 2 chan C
  always_comb
  begin
    case (act_reg)
      ffr_pkg::ACT_CHAN_A: act_mask = 3'h1;
      ffr_pkg::ACT_CHAN_B: act_mask = 3'h2;
      ffr_pkg::ACT_ALL: act_mask = 3'h7;
      default: act_mask = 3'h0;
    endcase
  end

  assign fi.disable_abc = (state_reg == ffr_pkg::FFR_IDLE) ? 3'h0 : act_mask;
  assign fi.soft_start_abc = ss_reg ? act_mask : 3'h0;

endmodule : ffr_flag_handler

// ==== ffr_fault_flag_response.sv ====
/*
  Fault flag response top: flag configuration registers, global delay select,
  supply overvoltage debounce and one response handler per fault flag.
  Assumes detected flags are levels synchronous to clk_sys and a simple
  byte register port addressed by the printed register addresses.
*/
`timescale 1ns/1ps
module ffr_fault_flag_response #(
  parameter int unsigned TICK_CYCLES = ffr_pkg::TICK_CYCLES,
  parameter int unsigned DEB_LONG_CYCLES = ffr_pkg::DEB_LONG_CYCLES,
  parameter int unsigned DEB_SHORT_CYCLES = ffr_pkg::DEB_SHORT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sense1_chan_a_overcurrent,
  input wire logic sense1_chan_b_overcurrent,
  input wire logic sense2_chan_a_overcurrent,
  input wire logic sense2_chan_b_overcurrent,
  input wire logic chan_a_overvolt,
  input wire logic chan_b_overvolt,
  input wire logic chan_a_undervolt,
  input wire logic chan_b_undervolt,
  input wire logic chan_c_overcurrent,
  input wire logic line_sense_fault,
  input wire logic overtemp_one,
  input wire logic overtemp_two,
  input wire logic external_fault_input,
  input wire logic supply_overvoltage,
  input wire logic power_on_request,
  output logic chan_a_disable,
  output logic chan_b_disable,
  output logic chan_c_disable,
  output logic chan_a_soft_start,
  output logic chan_b_soft_start,
  output logic chan_c_soft_start,
  output logic supply_ov_flag,
  output logic part_restart
);

  localparam int unsigned NF = ffr_pkg::NUM_FLAGS;

  // Register file
  logic [7:0] cfg_reg [0:ffr_pkg::NUM_CFG_REGS-1];
  logic [7:0] cfg_next [0:ffr_pkg::NUM_CFG_REGS-1];
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [15:0] addr_off;
  logic addr_hit;
  logic [2:0] addr_idx;

  assign addr_off = reg_addr - ffr_pkg::ADDR_CFG_FIRST;
  assign addr_hit = (reg_addr >= ffr_pkg::ADDR_CFG_FIRST) && (reg_addr <= ffr_pkg::ADDR_GLOBAL);
  assign addr_idx = addr_off[2:0];

  always_comb
  begin
    for (int i = 0; i < ffr_pkg::NUM_CFG_REGS; i++)
      cfg_next[i] = cfg_reg[i];
    if (reg_wr && addr_hit)
      cfg_next[addr_idx] = reg_wdata;
    rvalid_next = reg_rd;
    // Unmapped addresses read back as zero
    rdata_next = 8'h00;
    if (reg_rd && addr_hit)
      rdata_next = cfg_reg[addr_idx];
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int i = 0; i < ffr_pkg::NUM_CFG_REGS - 1; i++)
        cfg_reg[i] <= ffr_pkg::CFG_RESET;
      cfg_reg[ffr_pkg::NUM_CFG_REGS-1] <= ffr_pkg::GLOBAL_RESET;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < ffr_pkg::NUM_CFG_REGS; i++)
        cfg_reg[i] <= cfg_next[i];
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  logic [7:0] glb;
  assign glb = cfg_reg[ffr_pkg::NUM_CFG_REGS-1];

  // Global delay select, shared by every flag
  logic [10:0] delay_ms;
  always_comb
  begin
    case (glb[ffr_pkg::GLB_DELAY_LSB +: 2])
      2'h0: delay_ms = ffr_pkg::DELAY_MS_0;
      2'h1: delay_ms = ffr_pkg::DELAY_MS_1;
      2'h2: delay_ms = ffr_pkg::DELAY_MS_2;
      default: delay_ms = ffr_pkg::DELAY_MS_3;
    endcase
  end

  // One millisecond tick; a shared prescaler keeps per-flag counters at 11 bits
  logic [31:0] pre_reg, pre_next;
  logic tick_reg, tick_next;

  always_comb
  begin
    tick_next = 1'b0;
    pre_next = pre_reg + 32'h0000_0001;
    if (pre_reg >= 32'(TICK_CYCLES - 1))
    begin
      pre_next = 32'h0000_0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pre_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_next;
      tick_reg <= tick_next;
    end
  end

  // Supply overvoltage: set after the condition holds for the debounce time
  logic [31:0] deb_reg, deb_next;
  logic ov_reg, ov_next;
  logic restart_reg, restart_next;
  logic ov_enabled;
  logic [31:0] deb_limit;

  assign ov_enabled = !glb[ffr_pkg::GLB_OV_IGNORE_BIT];
  assign deb_limit = glb[ffr_pkg::GLB_OV_DEB_BIT] ? 32'(DEB_SHORT_CYCLES) : 32'(DEB_LONG_CYCLES);

  always_comb
  begin
    deb_next = 32'h0000_0000;
    ov_next = ov_reg;
    restart_next = 1'b0;
    if (!ov_enabled)
      ov_next = 1'b0;
    else if (supply_overvoltage)
    begin
      if (deb_reg + 32'h0000_0001 >= deb_limit)
      begin
        ov_next = 1'b1;
        deb_next = deb_reg;
      end
      else
        deb_next = deb_reg + 32'h0000_0001;
    end
    else
    begin
      ov_next = 1'b0;
      restart_next = ov_reg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      deb_reg <= 32'h0000_0000;
      ov_reg <= 1'b0;
      restart_reg <= 1'b0;
    end
    else
    begin
      deb_reg <= deb_next;
      ov_reg <= ov_next;
      restart_reg <= restart_next;
    end
  end

  assign supply_ov_flag = ov_reg;
  assign part_restart = restart_reg;

  // Per-flag handlers
  logic [NF-1:0] flags;
  assign flags = {external_fault_input, overtemp_two, overtemp_one, line_sense_fault,
                  chan_c_overcurrent, chan_b_undervolt, chan_a_undervolt, chan_b_overvolt,
                  chan_a_overvolt, sense2_chan_b_overcurrent, sense2_chan_a_overcurrent,
                  sense1_chan_b_overcurrent, sense1_chan_a_overcurrent};

  logic [2:0] dis_vec [0:NF-1];
  logic [2:0] ss_vec [0:NF-1];

  for (genvar g = 0; g < NF; g++)
  begin : g_flag
    ffr_flag_if fif ();
    assign fif.flag = flags[g];
    assign fif.tick = tick_reg;
    assign fif.delay_ms = delay_ms;
    assign fif.power_on_request = power_on_request;
    if (g == ffr_pkg::FLAG_EXT)
    begin : g_ext
      assign fif.cfg = glb[ffr_pkg::NIB_LOW_LSB +: 4];
    end
    else if (g % 2 == 1)
    begin : g_high
      assign fif.cfg = cfg_reg[g / 2][ffr_pkg::NIB_HIGH_LSB +: 4];
    end
    else
    begin : g_low
      assign fif.cfg = cfg_reg[g / 2][ffr_pkg::NIB_LOW_LSB +: 4];
    end
    ffr_flag_handler u_handler (
      .clk_sys(clk_sys),
      .reset(reset),
      .fi(fif.handler)
    );
    assign dis_vec[g] = fif.disable_abc;
    assign ss_vec[g] = fif.soft_start_abc;
  end

  // Combine handlers; supply overvoltage shuts down every channel while set
  logic [2:0] dis_reg, dis_next;
  logic [2:0] ss_reg, ss_next;

  always_comb
  begin
    dis_next = ov_reg ? 3'h7 : 3'h0;
    ss_next = 3'h0;
    for (int i = 0; i < NF; i++)
    begin
      dis_next = dis_next | dis_vec[i];
      ss_next = ss_next | ss_vec[i];
    end
    // A soft start is only asked for channels no other flag still holds off
    ss_next = ss_next & ~dis_next;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      dis_reg <= 3'h0;
      ss_reg <= 3'h0;
    end
    else
    begin
      dis_reg <= dis_next;
      ss_reg <= ss_next;
    end
  end

  assign chan_a_disable = dis_reg[0];
  assign chan_b_disable = dis_reg[1];
  assign chan_c_disable = dis_reg[2];
  assign chan_a_soft_start = ss_reg[0];
  assign chan_b_soft_start = ss_reg[1];
  assign chan_c_soft_start = ss_reg[2];

endmodule : ffr_fault_flag_response

// ==== ffr_checker.sv ====
/*
  Port checker for the fault flag response top.
  Assumes it is bound to the top and sees only its ports.
*/
`timescale 1ns/1ps
module ffr_checker #(
  parameter int unsigned DEB_SHORT_CYCLES = 80
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic supply_overvoltage,
  input wire logic chan_a_disable,
  input wire logic chan_b_disable,
  input wire logic chan_c_disable,
  input wire logic chan_a_soft_start,
  input wire logic supply_ov_flag,
  input wire logic part_restart
);
  logic [15:0] run_reg;
  logic [15:0] run_next;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  always_comb
  begin
    run_next = supply_overvoltage ? run_reg + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk_sys)
  begin
    run_reg <= reset ? 16'h0000 : run_next;
  end
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  chk_read_quiet: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without strobe");
  chk_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data not zero while idle");
  chk_soft_start: assert property (chan_a_soft_start |-> !chan_a_disable ##1 !chan_a_soft_start)
    else $error("soft start pulse malformed");
  chk_ov_disables: assert property (supply_ov_flag |=> chan_a_disable && chan_b_disable && chan_c_disable)
    else $error("overvoltage flag did not disable all");
  chk_ov_clear: assert property (supply_ov_flag && !supply_overvoltage |=> !supply_ov_flag && part_restart)
    else $error("overvoltage flag clear without restart");
  chk_restart_pulse: assert property (part_restart |-> $past(supply_ov_flag) ##1 !part_restart)
    else $error("restart pulse without flag clear");
  chk_ov_debounce: assert property ($rose(supply_ov_flag) |-> run_reg >= DEB_SHORT_CYCLES - 1)
    else $error("overvoltage flag set before debounce");
  cover property (chan_a_soft_start);
  cover property (part_restart);
  cover property (reg_rvalid && reg_rdata != 8'h00);
endmodule : ffr_checker

bind ffr_fault_flag_response ffr_checker #(.DEB_SHORT_CYCLES(DEB_SHORT_CYCLES)) u_chk (
  .clk_sys(clk_sys), .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .supply_overvoltage(supply_overvoltage), .chan_a_disable(chan_a_disable), .chan_b_disable(chan_b_disable),
  .chan_c_disable(chan_c_disable), .chan_a_soft_start(chan_a_soft_start), .supply_ov_flag(supply_ov_flag),
  .part_restart(part_restart)
);

// ==== testbench.sv ====
/*
  Self-checking bench for the fault flag response top.
  Assumes shortened tick and debounce parameters; 10 cycles stand for 1 ms.
*/
`timescale 1ns/1ps
module testbench;
  localparam int TICK = 10;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [12:0] flags = 13'h0000;
  logic supply_overvoltage = 1'b0;
  logic power_on_request = 1'b0;
  logic chan_a_disable, chan_b_disable, chan_c_disable;
  logic chan_a_soft_start, chan_b_soft_start, chan_c_soft_start;
  logic supply_ov_flag, part_restart;
  logic [7:0] dis;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  assign dis = {5'h00, chan_c_disable, chan_b_disable, chan_a_disable};
  always #12.5 clk_sys = ~clk_sys;

  ffr_fault_flag_response #(.TICK_CYCLES(TICK), .DEB_LONG_CYCLES(50), .DEB_SHORT_CYCLES(8)) DUT (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sense1_chan_a_overcurrent(flags[0]), .sense1_chan_b_overcurrent(flags[1]),
    .sense2_chan_a_overcurrent(flags[2]), .sense2_chan_b_overcurrent(flags[3]),
    .chan_a_overvolt(flags[4]), .chan_b_overvolt(flags[5]), .chan_a_undervolt(flags[6]),
    .chan_b_undervolt(flags[7]), .chan_c_overcurrent(flags[8]), .line_sense_fault(flags[9]),
    .overtemp_one(flags[10]), .overtemp_two(flags[11]), .external_fault_input(flags[12]),
    .supply_overvoltage(supply_overvoltage), .power_on_request(power_on_request),
    .chan_a_disable(chan_a_disable), .chan_b_disable(chan_b_disable), .chan_c_disable(chan_c_disable),
    .chan_a_soft_start(chan_a_soft_start), .chan_b_soft_start(chan_b_soft_start),
    .chan_c_soft_start(chan_c_soft_start), .supply_ov_flag(supply_ov_flag), .part_restart(part_restart)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    // Answer stands for one cycle only, so take it before the strobe drops
    check(reg_rvalid === 1'b1 ? reg_rdata : 8'hEE, exp);
    reg_rd = 1'b0;
  endtask : rd

  task automatic cfg(input int f, input logic [3:0] nib);
    wr(16'hFE00 + 16'(f / 2), f % 2 == 1 ? {nib, 4'h0} : {4'h0, nib});
  endtask : cfg

  task automatic t_regs();
    for (int i = 0; i < 7; i++)
    begin
      rd(16'hFE00 + 16'(i), 8'h00);
      wr(16'hFE00 + 16'(i), 8'hA0 + 8'(i));
      rd(16'hFE00 + 16'(i), 8'hA0 + 8'(i));
    end
    wr(16'hFE07, 8'h5A);
    rd(16'hFE07, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_actions();
    for (int f = 0; f < 13; f++)
    begin
      for (int act = 0; act < 4; act++)
      begin
        cfg(f, {2'(act), 2'h1});
        flags[f] = 1'b1;
        cyc(3);
        check(dis, act == 3 ? 8'h07 : 8'(act));
        flags[f] = 1'b0;
        cyc(3);
        check(dis, 8'h00);
      end
    end
    $display("test actions done");
  endtask : t_actions

  task automatic t_latch();
    for (int k = 0; k < 4; k++)
    begin
      cfg(k < 2 ? 1 : 12, {2'h3, 2'(2 + k % 2)});
      flags[k < 2 ? 1 : 12] = 1'b1;
      cyc(3);
      flags[k < 2 ? 1 : 12] = 1'b0;
      cyc(20);
      check(dis, 8'h07);
      power_on_request = 1'b1;
      cyc(1);
      power_on_request = 1'b0;
      cyc(3);
      check(dis, 8'h00);
    end
    $display("test latch done");
  endtask : t_latch

  task automatic t_delay(input logic [1:0] code, input int ms, input logic [1:0] act);
    int n;
    logic [2:0] mask;
    n = 0;
    mask = act == 2'h3 ? 3'h7 : {1'b0, act};
    wr(16'hFE06, {code, 6'h00});
    cfg(0, {act, 2'h0});
    flags[0] = 1'b1;
    cyc(3);
    flags[0] = 1'b0;
    cyc(TICK * ms / 2);
    // Re-set mid-delay; a count that kept running would finish early
    flags[0] = 1'b1;
    cyc(3);
    flags[0] = 1'b0;
    cyc(TICK * (ms - 2));
    check(dis, {5'h00, mask});
    while ((chan_a_soft_start | chan_b_soft_start) !== 1'b1 && n < 3 * TICK)
    begin
      cyc(1);
      n++;
    end
    check({chan_c_soft_start, chan_b_soft_start, chan_a_soft_start, 2'h0, dis[2:0]}, {mask, 5'h00});
    $display("test delay done");
  endtask : t_delay

  task automatic t_supply();
    wr(16'hFE06, 8'h10);
    supply_overvoltage = 1'b1;
    cyc(5);
    supply_overvoltage = 1'b0;
    cyc(3);
    check({7'h00, supply_ov_flag}, 8'h00);
    supply_overvoltage = 1'b1;
    cyc(6);
    check({7'h00, supply_ov_flag}, 8'h00);
    cyc(8);
    check({supply_ov_flag, dis[6:0]}, 8'h87);
    supply_overvoltage = 1'b0;
    cyc(1);
    check({part_restart, supply_ov_flag, 6'h00}, 8'h80);
    wr(16'hFE06, 8'h00);
    supply_overvoltage = 1'b1;
    cyc(40);
    check({7'h00, supply_ov_flag}, 8'h00);
    cyc(20);
    check({7'h00, supply_ov_flag}, 8'h01);
    supply_overvoltage = 1'b0;
    cyc(3);
    wr(16'hFE06, 8'h20);
    supply_overvoltage = 1'b1;
    cyc(80);
    check({supply_ov_flag, dis[6:0]}, 8'h00);
    supply_overvoltage = 1'b0;
    cyc(1);
    check({7'h00, part_restart}, 8'h00);
    $display("test supply done");
  endtask : t_supply

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Ceiling sits well above the four delay runs of about 56k cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  initial
  begin
    cyc(4);
    reset = 1'b0;
    t_regs();
    t_actions();
    t_latch();
    t_delay(2'h0, 250, 2'h1);
    t_delay(2'h1, 500, 2'h2);
    t_delay(2'h2, 1000, 2'h3);
    t_delay(2'h3, 2000, 2'h1);
    t_supply();
    end_of_test();
  end
endmodule : testbench
